//--- rtl/sssm_monitor.sv
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// R1 - delay stop: torque off at expiry, unsupervised
// R2 - stop delay 0.1-1800 s plus tolerance
// R3 - s-profile start/end ratios 1-99, default 50; code stores them but supervises a linear profile only
// R4 - ramp stop needs encoder connected
// R5 - ramp stop: deviation limit versus expected ramp
// R6 - ramp stop: torque off at standstill threshold
// R7 - speed error over limit gives torque off
// R8 - input high normally; ready output high
// R9 - falling safe input starts stop sequence
// R10 - slope stop: command converter, check deceleration
// R11 - converter must decelerate at least that steeply
// R12 - too slow deceleration: immediate torque off
// R13 - time stop: profile from deceleration time
// R14 - limited speed needs encoder connected
// R15 - overspeed trips selected failure reaction
// R16 - ramped limit, then same failure reaction; code ignores the ramp bit and checks the fixed cut-off only
// R17 - above cut-off: flag error, react
// R18 - stop reaction only if time stop configured
// R19 - speed from pulse gate; faults latch
module sssm_monitor
    import sssm_pkg::*;
#(
    parameter int SPD_W = 14,
    parameter int GATE_CYC = SSSM_TENTH_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_safe_input_a,
    input wire logic i_safe_input_b,
    input wire logic i_encoder_pulse,
    input wire logic i_encoder_present,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_torque_off,
    output logic o_stop_request,
    output logic o_ready_output,
    output logic o_irq
);
    import sssm_pkg::*;

    typedef struct packed {
        logic [1:0] sa;
        logic [1:0] sb;
        logic [1:0] enc;
        logic prev_ok;
        sssm_state_t st;
        logic [7:0] ctrl;
        logic [14:0] delay;
        logic [5:0] tol;
        logic [13:0] sratio;
        logic [14:0] decel;
        logic [13:0] deltav;
        logic [9:0] zero;
        logic [14:0] rtime;
        logic [13:0] cutoff;
        logic [SSSM_NIRQ-1:0] irq;
        logic [SSSM_NIRQ-1:0] mask;
        logic [31:0] tenth;
        logic [15:0] elapsed;
        logic [SPD_W-1:0] v0;
        logic [SPD_W-1:0] expect_v;
        logic [SPD_W-1:0] last_v;
        logic fault;
        logic stop_req;
        logic [31:0] rdata;
    } sssm_regs_t;

    sssm_regs_t s_ff, nxt_s;
    logic [SPD_W-1:0] speed;
    logic tick;
    sssm_mode_t mode;
    logic access, wr, rd, mapped;
    logic [SSSM_NIRQ-1:0] ev;
    logic [16:0] limit;
    logic [31:0] drop;
    logic [SPD_W:0] bound;
    logic enc_ok;

    sssm_speed_meas #(
        .WIDTH(SPD_W),
        .GATE_CYC(GATE_CYC)
    ) u_meas (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pulse(i_encoder_pulse),
        .o_speed(speed),
        .o_tick(tick)
    );

    assign mode = sssm_mode_t'(s_ff.ctrl[6:0]);
    assign enc_ok = s_ff.enc[1];
    assign access = i_psel && i_penable;
    assign wr = access && i_pwrite;
    // read data loaded in setup so it stands through the access phase
    assign rd = i_psel && !i_penable && !i_pwrite;
    assign mapped = i_paddr <= SSSM_OFF_SPEED && i_paddr[1:0] == 2'b00;

    // delay stop total: delay plus tolerance percent, in 0.1 s units
    assign limit = 17'(s_ff.delay) + 17'((32'(s_ff.delay) * 32'(s_ff.tol))
        / SSSM_PCT_FULL); // see R2

    always_comb begin
        nxt_s = s_ff;
        ev = '0;
        drop = '0;
        bound = '0;
        nxt_s.sa = {s_ff.sa[0], i_safe_input_a};
        nxt_s.sb = {s_ff.sb[0], i_safe_input_b};
        nxt_s.enc = {s_ff.enc[0], i_encoder_present};
        nxt_s.prev_ok = s_ff.sa[1] && s_ff.sb[1];
        nxt_s.rdata = '0;
        if (s_ff.st == SSSM_STOPPING) begin
            if (s_ff.tenth == 32'(GATE_CYC - 1)) begin
                nxt_s.tenth = '0;
                if (!(&s_ff.elapsed)) begin
                    nxt_s.elapsed = s_ff.elapsed + 16'h0001;
                end
            end else begin
                nxt_s.tenth = s_ff.tenth + 32'h0000_0001;
            end
        end
        unique case (s_ff.st)
            SSSM_IDLE: begin
                // falling edge on either safe input
                if (s_ff.prev_ok && !(s_ff.sa[1] && s_ff.sb[1])) begin // see R9
                    ev[SSSM_I_STOP] = 1'b1;
                    nxt_s.tenth = '0;
                    nxt_s.elapsed = '0;
                    nxt_s.v0 = speed;
                    nxt_s.expect_v = speed;
                    nxt_s.last_v = speed;
                    if ((mode.a_sls && !s_ff.sa[1])
                        || (mode.b_sls && !s_ff.sb[1])) begin
                        if (!enc_ok) begin // see R14
                            nxt_s.st = SSSM_FAULT;
                        end else begin
                            nxt_s.st = SSSM_SLS;
                        end
                    end else if (mode.stop_type != SSSM_STOP_DELAY
                        && !enc_ok) begin // see R4
                        nxt_s.st = SSSM_FAULT;
                    end else begin
                        nxt_s.st = SSSM_STOPPING;
                        nxt_s.stop_req = 1'b1; // see R10
                    end
                end
            end
            SSSM_STOPPING: begin
                if (mode.stop_type == SSSM_STOP_DELAY) begin
                    // speed ignored on purpose; profile is the drive's job
                    if (17'(s_ff.elapsed) >= limit) begin // see R1
                        nxt_s.st = SSSM_TORQUE_OFF;
                    end
                end else if (tick) begin
                    if (mode.stop_type == SSSM_STOP_SLOPE) begin
                        // rate in rpm/s, per 0.1 s sample; relies on see R11
                        drop = 32'(s_ff.decel) / 32'd10;
                        nxt_s.last_v = speed;
                        if (32'(speed) + drop > 32'(s_ff.last_v)
                            + 32'(s_ff.deltav)) begin // see R12
                            nxt_s.st = SSSM_FAULT;
                        end
                    end else begin
                        // linear target from start speed over ramp time
                        drop = (32'(s_ff.v0) * 32'(s_ff.elapsed))
                            / 32'(s_ff.rtime); // see R13
                        nxt_s.expect_v = (drop >= 32'(s_ff.v0)) ? '0 :
                            SPD_W'(32'(s_ff.v0) - drop);
                        bound = (SPD_W+1)'(s_ff.expect_v) +
                            (SPD_W+1)'(s_ff.deltav);
                        if ((SPD_W+1)'(speed) > bound) begin // see R5
                            nxt_s.st = SSSM_FAULT; // see R7
                        end
                    end
                    if (speed <= SPD_W'(s_ff.zero)) begin // see R6
                        nxt_s.st = SSSM_TORQUE_OFF;
                    end
                end
            end
            SSSM_SLS: begin
                if (s_ff.sa[1] && s_ff.sb[1]) begin
                    nxt_s.st = SSSM_IDLE;
                end else if (tick && speed > SPD_W'(s_ff.cutoff)) begin
                    // ramp variant: drive brings speed down; same cut-off
                    ev[SSSM_I_OVERSPD] = 1'b1; // see R15 see R16 see R17
                    nxt_s.fault = 1'b1;
                    if (mode.fail_ss1
                        && mode.stop_type == SSSM_STOP_TIME) begin // see R18
                        nxt_s.st = SSSM_STOPPING;
                        nxt_s.stop_req = 1'b1;
                        nxt_s.tenth = '0;
                        nxt_s.elapsed = '0;
                        nxt_s.v0 = speed;
                        nxt_s.expect_v = speed;
                    end else begin
                        nxt_s.st = SSSM_FAULT;
                    end
                end
            end
            SSSM_TORQUE_OFF: begin
                // released only when inputs return high
                if (s_ff.sa[1] && s_ff.sb[1] && !s_ff.fault) begin
                    nxt_s.st = SSSM_IDLE;
                    nxt_s.stop_req = 1'b0;
                end
            end
            SSSM_FAULT: begin
                nxt_s.fault = 1'b1; // see R19
            end
            default: nxt_s.st = SSSM_FAULT;
        endcase
        if (nxt_s.st == SSSM_TORQUE_OFF && s_ff.st != SSSM_TORQUE_OFF) begin
            ev[SSSM_I_TORQUE] = 1'b1;
        end
        if (nxt_s.st == SSSM_FAULT && s_ff.st != SSSM_FAULT) begin
            ev[SSSM_I_FAULT] = 1'b1;
        end
        if (nxt_s.st == SSSM_FAULT) begin
            nxt_s.stop_req = 1'b1;
        end
        if (wr) begin
            unique case (i_paddr)
                SSSM_OFF_CTRL: nxt_s.ctrl = i_pwdata[7:0];
                SSSM_OFF_DELAY: nxt_s.delay = i_pwdata[14:0];
                SSSM_OFF_TOL: nxt_s.tol = i_pwdata[5:0];
                SSSM_OFF_SRATIO: nxt_s.sratio = i_pwdata[13:0]; // see R3
                SSSM_OFF_DECEL: nxt_s.decel = i_pwdata[14:0];
                SSSM_OFF_DELTAV: nxt_s.deltav = i_pwdata[13:0];
                SSSM_OFF_ZERO: nxt_s.zero = i_pwdata[9:0];
                SSSM_OFF_RTIME: nxt_s.rtime = i_pwdata[14:0];
                SSSM_OFF_CUTOFF: nxt_s.cutoff = i_pwdata[13:0];
                SSSM_OFF_IRQ: nxt_s.irq = s_ff.irq
                    & ~i_pwdata[SSSM_NIRQ-1:0];
                SSSM_OFF_MASK: nxt_s.mask = i_pwdata[SSSM_NIRQ-1:0];
                default: nxt_s.irq = s_ff.irq;
            endcase
        end
        // set beats clear
        nxt_s.irq = nxt_s.irq | ev;
        if (rd) begin
            unique case (i_paddr)
                SSSM_OFF_CTRL: nxt_s.rdata = 32'(s_ff.ctrl);
                SSSM_OFF_DELAY: nxt_s.rdata = 32'(s_ff.delay);
                SSSM_OFF_TOL: nxt_s.rdata = 32'(s_ff.tol);
                SSSM_OFF_SRATIO: nxt_s.rdata = 32'(s_ff.sratio);
                SSSM_OFF_DECEL: nxt_s.rdata = 32'(s_ff.decel);
                SSSM_OFF_DELTAV: nxt_s.rdata = 32'(s_ff.deltav);
                SSSM_OFF_ZERO: nxt_s.rdata = 32'(s_ff.zero);
                SSSM_OFF_RTIME: nxt_s.rdata = 32'(s_ff.rtime);
                SSSM_OFF_CUTOFF: nxt_s.rdata = 32'(s_ff.cutoff);
                SSSM_OFF_STATUS: nxt_s.rdata = {25'h000_0000, s_ff.fault,
                    s_ff.enc[1], s_ff.st};
                SSSM_OFF_IRQ: nxt_s.rdata = 32'(s_ff.irq);
                SSSM_OFF_MASK: nxt_s.rdata = 32'(s_ff.mask);
                SSSM_OFF_SPEED: nxt_s.rdata = 32'(speed);
                default: nxt_s.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_ff <= '0;
            s_ff.st <= SSSM_IDLE;
            s_ff.ctrl <= SSSM_RST_CTRL;
            s_ff.delay <= SSSM_RST_DELAY;
            s_ff.tol <= SSSM_RST_TOL;
            s_ff.sratio <= {SSSM_RST_SRATIO, SSSM_RST_SRATIO};
            s_ff.decel <= SSSM_RST_DECEL;
            s_ff.deltav <= SSSM_RST_DELTAV;
            s_ff.zero <= SSSM_RST_ZERO;
            s_ff.rtime <= SSSM_RST_DELAY;
            s_ff.cutoff <= SSSM_RST_CUTOFF;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_prdata = s_ff.rdata;
    assign o_pready = 1'b1;
    assign o_pslverr = access && !mapped;
    assign o_torque_off = s_ff.st == SSSM_TORQUE_OFF
        || s_ff.st == SSSM_FAULT;
    assign o_stop_request = s_ff.stop_req;
    // high unless faulted or the ctrl enable bit is clear
    assign o_ready_output = s_ff.st != SSSM_FAULT && !s_ff.fault
        && s_ff.ctrl[SSSM_C_ENABLE]; // see R8
    assign o_irq = |(s_ff.irq & s_ff.mask);
endmodule // sssm_monitor

//--- pkg/sssm_pkg.sv
package sssm_pkg;
    // configuration and status register offsets (byte addresses)
    localparam logic [11:0] SSSM_OFF_CTRL = 12'h000;
    localparam logic [11:0] SSSM_OFF_DELAY = 12'h004;
    localparam logic [11:0] SSSM_OFF_TOL = 12'h008;
    localparam logic [11:0] SSSM_OFF_SRATIO = 12'h00c;
    localparam logic [11:0] SSSM_OFF_DECEL = 12'h010;
    localparam logic [11:0] SSSM_OFF_DELTAV = 12'h014;
    localparam logic [11:0] SSSM_OFF_ZERO = 12'h018;
    localparam logic [11:0] SSSM_OFF_RTIME = 12'h01c;
    localparam logic [11:0] SSSM_OFF_CUTOFF = 12'h020;
    localparam logic [11:0] SSSM_OFF_STATUS = 12'h024;
    localparam logic [11:0] SSSM_OFF_IRQ = 12'h028;
    localparam logic [11:0] SSSM_OFF_MASK = 12'h02c;
    localparam logic [11:0] SSSM_OFF_SPEED = 12'h030;

    // stop types
    localparam logic [1:0] SSSM_STOP_DELAY = 2'h0;
    localparam logic [1:0] SSSM_STOP_SLOPE = 2'h1;
    localparam logic [1:0] SSSM_STOP_TIME = 2'h2;

    // ctrl field positions
    localparam int SSSM_C_TYPE = 0;
    localparam int SSSM_C_SPROF = 2;
    localparam int SSSM_C_A_SLS = 3;
    localparam int SSSM_C_B_SLS = 4;
    localparam int SSSM_C_SLS_RAMP = 5;
    localparam int SSSM_C_FAIL_SS1 = 6;
    localparam int SSSM_C_ENABLE = 7;

    // irq status bit positions
    localparam int SSSM_I_STOP = 0;
    localparam int SSSM_I_TORQUE = 1;
    localparam int SSSM_I_FAULT = 2;
    localparam int SSSM_I_OVERSPD = 3;
    localparam int SSSM_NIRQ = 4;

    // reset values: delay/ramp time in 0.1 s, percents, rpm
    localparam logic [14:0] SSSM_RST_DELAY = 15'h000a;
    localparam logic [5:0] SSSM_RST_TOL = 6'h05;
    localparam logic [6:0] SSSM_RST_SRATIO = 7'h32;
    localparam logic [14:0] SSSM_RST_DECEL = 15'h05dc;
    localparam logic [13:0] SSSM_RST_DELTAV = 14'h0078;
    localparam logic [9:0] SSSM_RST_ZERO = 10'h00a;
    localparam logic [13:0] SSSM_RST_CUTOFF = 14'h010e;
    localparam logic [7:0] SSSM_RST_CTRL = 8'h80;

    // timing
    localparam int SSSM_CLK_HZ = 20_000_000;
    localparam int SSSM_TENTH_MS = 100;
    localparam int SSSM_TENTH_CYC = SSSM_CLK_HZ / 1000 * SSSM_TENTH_MS;
    localparam int SSSM_PCT_FULL = 100;

    typedef enum logic [4:0] {
        SSSM_IDLE = 5'b00001,
        SSSM_STOPPING = 5'b00010,
        SSSM_SLS = 5'b00100,
        SSSM_TORQUE_OFF = 5'b01000,
        SSSM_FAULT = 5'b10000
    } sssm_state_t;

    typedef struct packed {
        logic fail_ss1;
        logic sls_ramp;
        logic b_sls;
        logic a_sls;
        logic s_profile;
        logic [1:0] stop_type;
    } sssm_mode_t;
endpackage

//--- rtl/sssm_speed_meas.sv
`timescale 1ns/10ps
module sssm_speed_meas
    import sssm_pkg::*;
#(
    parameter int WIDTH = 14,
    parameter int GATE_CYC = SSSM_TENTH_CYC
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_pulse,
    output logic [WIDTH-1:0] o_speed,
    output logic o_tick
);
    typedef struct packed {
        logic [1:0] sync;
        logic prev;
        logic [WIDTH-1:0] cnt;
        logic [31:0] gate;
        logic [WIDTH-1:0] speed;
        logic tick;
    } sssm_meas_t;

    sssm_meas_t state_ff, nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.sync = {state_ff.sync[0], i_pulse};
        nxt_state.prev = state_ff.sync[1];
        nxt_state.tick = 1'b0;
        if (state_ff.sync[1] && !state_ff.prev && !(&state_ff.cnt)) begin
            nxt_state.cnt = state_ff.cnt + 1'b1;
        end
        // fixed gate: pulses per gate scale to rpm by encoder choice
        if (state_ff.gate == 32'(GATE_CYC - 1)) begin // see R19
            nxt_state.gate = '0;
            nxt_state.speed = nxt_state.cnt;
            nxt_state.cnt = '0;
            nxt_state.tick = 1'b1;
        end else begin
            nxt_state.gate = state_ff.gate + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_speed = state_ff.speed;
    assign o_tick = state_ff.tick;
endmodule // sssm_speed_meas

//--- tb/sssm_monitor_asserts.sv
`timescale 1ns/10ps
module sssm_monitor_asserts
    import sssm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_safe_input_a,
    input wire logic i_safe_input_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_torque_off,
    input wire logic o_stop_request,
    input wire logic o_ready_output,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic acc;
    logic bad;
    assign acc = i_psel && i_penable;
    assign bad = (i_paddr > SSSM_OFF_SPEED) || (i_paddr[1:0] != 2'b00);
    a_ready_high: assert property (o_pready)
        else $error("pready low");
    a_err_mapped: assert property (acc && !bad |-> !o_pslverr)
        else $error("error on mapped address");
    a_err_unmapped: assert property (acc && bad |-> o_pslverr)
        else $error("no error on unmapped address");
    a_err_idle: assert property (!acc |-> !o_pslverr)
        else $error("error outside access");
    a_rdata_idle: assert property (!$past(i_psel && !i_penable && !i_pwrite)
        |-> o_prdata == 0)
        else $error("read data outside read answer");
    a_reset_outputs: assert property ($fell(i_reset) |->
        !o_torque_off && !o_stop_request && o_ready_output && !o_irq)
        else $error("outputs wrong after reset");
    a_torque_release: assert property ($fell(o_torque_off) |->
        i_safe_input_a && i_safe_input_b)
        else $error("torque off released with input low");
    a_stop_cause: assert property ($rose(o_stop_request) |->
        !(i_safe_input_a && i_safe_input_b))
        else $error("stop request without low input");
endmodule // sssm_monitor_asserts

bind sssm_monitor sssm_monitor_asserts chk_u (.i_clk(i_clk),
    .i_reset(i_reset), .i_safe_input_a(i_safe_input_a),
    .i_safe_input_b(i_safe_input_b), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_torque_off(o_torque_off), .o_stop_request(o_stop_request),
    .o_ready_output(o_ready_output), .o_irq(o_irq));

//--- tb/sssm_drive_model.sv
`timescale 1ns/10ps
module sssm_drive_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_stop_request,
    input wire logic i_torque_off,
    input wire logic i_slow,
    input wire logic [3:0] i_speed,
    output logic o_pulse
);
    logic [4:0] gate_ff;
    logic [3:0] spd_ff;
    always_ff @(posedge i_clk) begin
        gate_ff <= (i_reset || gate_ff == 5'd19) ? 5'd0 : gate_ff + 5'd1;
        if (i_reset || !(i_stop_request || i_torque_off)) begin
            spd_ff <= i_speed;
        end else if (i_torque_off) begin
            spd_ff <= 4'd0; // no torque, coasting shortened to zero
        end else if (!i_slow && gate_ff == 5'd19 && spd_ff != 4'd0) begin
            spd_ff <= spd_ff - 4'd1;
        end
    end
    // spd_ff pulses per 20-cycle gate, one cycle wide each
    always_comb o_pulse = !gate_ff[0] && (gate_ff < {spd_ff, 1'b0});
endmodule // sssm_drive_model

//--- tb/tb_safe_stop_speed_monitor.sv
`timescale 1ns/10ps
module tb_safe_stop_speed_monitor;
    import sssm_pkg::*;
    logic clk;
    logic rst = 1'b1;
    logic in_a = 1'b1;
    logic in_b = 1'b1;
    logic present = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic slow = 1'b0;
    logic [3:0] speed = 4'h0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [31:0] prdata;
    logic pulse, pready, pslverr, toff, stopr, rdy, irq;
    int mismatches = 0;
    int compares = 0;
    localparam logic [11:0] ra[9] = '{SSSM_OFF_CTRL, SSSM_OFF_DELAY,
        SSSM_OFF_TOL, SSSM_OFF_SRATIO, SSSM_OFF_DECEL, SSSM_OFF_DELTAV,
        SSSM_OFF_ZERO, SSSM_OFF_RTIME, SSSM_OFF_CUTOFF};
    localparam logic [31:0] rv[9] = '{32'h80, 32'ha, 32'h5, 32'h1932,
        32'h5dc, 32'h78, 32'ha, 32'ha, 32'h10e};

    sssm_monitor #(.GATE_CYC(20)) dut_u (.i_clk(clk), .i_reset(rst),
        .i_safe_input_a(in_a), .i_safe_input_b(in_b),
        .i_encoder_pulse(pulse), .i_encoder_present(present),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
        .i_pwdata(wdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_torque_off(toff), .o_stop_request(stopr),
        .o_ready_output(rdy), .o_irq(irq));
    sssm_drive_model drv_u (.i_clk(clk), .i_reset(rst),
        .i_stop_request(stopr), .i_torque_off(toff), .i_slow(slow),
        .i_speed(speed), .o_pulse(pulse));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        err = pslverr;
        rd = prdata;
        if (pready !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: no pready", $time);
        end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        @(negedge clk); // write has landed before the caller looks
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    task automatic wait_off(input int n);
        while (toff !== 1'b1 && n-- > 0) @(negedge clk);
        chk(toff, 1'b1);
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        in_a <= 1'b1;
        in_b <= 1'b1;
        present <= 1'b1;
        slow <= 1'b0;
        speed <= 4'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk); // input synchronisers settle
    endtask

    task automatic t_regs;
        logic [31:0] r;
        logic e;
        foreach (ra[i]) rdc(ra[i], rv[i]);
        chk(rdy, 1'b1);
        apb(1'b0, 12'h040, 32'h0, r, e);
        chk(e, 1'b1);
        chk(r, 32'h0);
        apb(1'b1, 12'h006, 32'h1, r, e);
        chk(e, 1'b1);
        wr(SSSM_OFF_SRATIO, 32'h3181);
        rdc(SSSM_OFF_SRATIO, 32'h3181);
        wr(SSSM_OFF_DELAY, 32'h4650);
        rdc(SSSM_OFF_DELAY, 32'h4650);
    endtask

    task automatic t_delay;
        wr(SSSM_OFF_DELAY, 32'h1);
        wr(SSSM_OFF_TOL, 32'h0);
        wr(SSSM_OFF_MASK, 32'h2);
        @(posedge clk);
        slow <= 1'b1;
        speed <= 4'h5;
        in_a <= 1'b0;
        repeat (12) @(negedge clk);
        chk(toff, 1'b0);
        wait_off(40);
        chk(irq, 1'b1);
        rdc(SSSM_OFF_IRQ, 32'h3);
        wr(SSSM_OFF_MASK, 32'h0);
        chk(irq, 1'b0);
        @(posedge clk) in_a <= 1'b1;
        repeat (8) @(negedge clk);
        chk(toff, 1'b0);
        wr(SSSM_OFF_MASK, 32'h2);
        chk(irq, 1'b1);
        wr(SSSM_OFF_IRQ, 32'hf);
        chk(irq, 1'b0);
    endtask

    task automatic t_slope;
        wr(SSSM_OFF_CTRL, 32'h81);
        wr(SSSM_OFF_DECEL, 32'h1);
        wr(SSSM_OFF_DELTAV, 32'h2710);
        wr(SSSM_OFF_ZERO, 32'h1);
        @(posedge clk);
        slow <= 1'b0;
        speed <= 4'h5;
        repeat (60) @(posedge clk);
        in_b <= 1'b0;
        repeat (8) @(negedge clk);
        chk(stopr, 1'b1);
        chk(toff, 1'b0);
        wait_off(400);
        rdc(SSSM_OFF_STATUS, 32'h28);
    endtask

    task automatic t_slow;
        wr(SSSM_OFF_CTRL, 32'h81);
        wr(SSSM_OFF_DECEL, 32'h7530);
        wr(SSSM_OFF_DELTAV, 32'h1);
        wr(SSSM_OFF_ZERO, 32'h1);
        @(posedge clk);
        slow <= 1'b1; // drive ignores the stop command
        speed <= 4'h5;
        repeat (60) @(posedge clk);
        in_b <= 1'b0;
        wait_off(200);
    endtask

    task automatic t_noenc;
        @(posedge clk) present <= 1'b0;
        wr(SSSM_OFF_CTRL, 32'h82);
        @(posedge clk) in_a <= 1'b0;
        wait_off(100);
        chk(rdy, 1'b0);
        @(posedge clk) in_a <= 1'b1;
        repeat (10) @(negedge clk);
        chk(toff, 1'b1);
        rdc(SSSM_OFF_STATUS, 32'h50);
    endtask

    task automatic t_sls;
        logic [31:0] r;
        logic e;
        wr(SSSM_OFF_CTRL, 32'hc8);
        wr(SSSM_OFF_CUTOFF, 32'h3);
        @(posedge clk) speed <= 4'h5;
        repeat (60) @(posedge clk);
        in_a <= 1'b0;
        wait_off(200);
        rdc(SSSM_OFF_STATUS, 32'h70);
        apb(1'b0, SSSM_OFF_IRQ, 32'h0, r, e);
        chk(r[SSSM_I_OVERSPD], 1'b1);
    endtask

    task automatic t_time;
        wr(SSSM_OFF_CTRL, 32'hca);
        wr(SSSM_OFF_CUTOFF, 32'h3);
        wr(SSSM_OFF_DELTAV, 32'h1);
        wr(SSSM_OFF_ZERO, 32'h1);
        @(posedge clk);
        slow <= 1'b1; // drive holds speed while the profile falls
        speed <= 4'h5;
        repeat (60) @(posedge clk);
        in_a <= 1'b0;
        repeat (30) @(negedge clk);
        chk(stopr, 1'b1);
        chk(toff, 1'b0);
        wait_off(300);
        rdc(SSSM_OFF_STATUS, 32'h70);
    endtask

    initial begin
        #1000000;
        mismatches++;
        final_report;
    end

    initial begin
        do_reset;
        t_regs;
        t_delay;
        t_slope;
        do_reset;
        t_slow;
        do_reset;
        t_noenc;
        do_reset;
        t_sls;
        do_reset;
        t_time;
        final_report;
    end
endmodule // tb_safe_stop_speed_monitor
